//--- hdl/rbm_mapper.sv
// ROM bank mapper: processor address decode, bank registers and memory strobes
`timescale 1ns/1ps
`default_nettype none
`include "rbm_defines.svh"

// How it works
// - The register at FRAME0_PAGE_SELECT holds the ROM page shown in window 0.
// - The register at FRAME1_PAGE_SELECT holds the ROM page shown in window 1 at 4000 to 7FFF.
// - The register at FRAME2_PAGE_SELECT holds the ROM page shown in window 2 at 8000 to BFFF in ROM mode.
// - Window 0 covers processor addresses 0000 up to just below 4000, each window 16 KB.
// - Bank n starts at ROM address n times 4000 in a 32-bank ROM.
// - Processor addresses 0000 to 03FF always reach the first 1024 bytes of ROM.
// - The physical bank is the written bank plus eight times the shift field, modulo 32.
// - In the FRAME2_RAM_CONTROL register bits 1:0 are the bank shift and bit 2 picks the RAM bank.
// - The ROM/RAM bit of FRAME2_RAM_CONTROL puts ROM (0) or external RAM (1) in window 2.
// - Bit 7 of FRAME2_RAM_CONTROL set makes the ROM board read only, clear allows writes.
module rbm_mapper (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Processor side
    input wire rbm_pkg::rbm_cpu_req_t cpu_req,
    output rbm_pkg::rbm_rd_t reg_rd,
    // Memory side
    output rbm_pkg::rbm_mem_t mem
);

    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] ctrl_r;
    logic [7:0] page0_r;
    logic [7:0] page1_r;
    logic [7:0] page2_r;
    logic reg_hit;

    assign reg_hit = (cpu_req.addr >= `RBM_ADDR_RAM_CTRL);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `RBM_RST_CTRL;
        end else if (cpu_req.wr && cpu_req.addr == `RBM_ADDR_RAM_CTRL) begin
            ctrl_r <= cpu_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            page0_r <= `RBM_RST_PAGE0;
            page1_r <= `RBM_RST_PAGE1;
            page2_r <= `RBM_RST_PAGE2;
        end else if (cpu_req.wr) begin
            if (cpu_req.addr == `RBM_ADDR_PAGE0) begin
                page0_r <= cpu_req.wdata;
            end
            if (cpu_req.addr == `RBM_ADDR_PAGE1) begin
                page1_r <= cpu_req.wdata;
            end
            if (cpu_req.addr == `RBM_ADDR_PAGE2) begin
                page2_r <= cpu_req.wdata;
            end
        end
    end

    // ****************************************
    // Register read back
    // ****************************************
    logic [7:0] rd_mux;

    always_comb begin
        unique case (cpu_req.addr[1:0])
            2'h0: rd_mux = ctrl_r;
            2'h1: rd_mux = page0_r;
            2'h2: rd_mux = page1_r;
            default: rd_mux = page2_r;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rd <= '0;
        end else begin
            reg_rd.valid <= cpu_req.rd && reg_hit;
            reg_rd.data <= (cpu_req.rd && reg_hit) ? rd_mux : 8'h00;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    logic [1:0] win;
    logic [1:0] shift;
    logic [4:0] bank_sel;
    logic [4:0] bank_phys;
    logic vec_area;
    logic win2_ram;
    logic any_req;

    assign win = cpu_req.addr[15:14];
    assign shift = ctrl_r[`RBM_CTRL_SHIFT_MSB:`RBM_CTRL_SHIFT_LSB];
    assign vec_area = (cpu_req.addr < `RBM_VEC_LIMIT);
    // ROM or RAM in window 2
    assign win2_ram = ctrl_r[`RBM_CTRL_RAMSEL_BIT];
    assign any_req = cpu_req.rd || cpu_req.wr;

    always_comb begin
        unique case (win)
            `RBM_WIN0: bank_sel = page0_r[`RBM_BANK_BITS-1:0];
            `RBM_WIN1: bank_sel = page1_r[`RBM_BANK_BITS-1:0];
            default: bank_sel = page2_r[`RBM_BANK_BITS-1:0];
        endcase
    end

    assign bank_phys = bank_sel + {shift, 3'h0};

    // ****************************************
    // Memory strobes
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem <= '0;
        end else begin
            mem.wdata <= cpu_req.wdata;
            mem.rom_rd <= 1'b0;
            mem.rom_wr <= 1'b0;
            mem.ram_rd <= 1'b0;
            mem.ram_wr <= 1'b0;
            mem.sys_rd <= 1'b0;
            mem.sys_wr <= 1'b0;
            if (any_req) begin
                if (win == `RBM_WIN3) begin
                    mem.sys_addr <= cpu_req.addr[13:0];
                    mem.sys_rd <= cpu_req.rd;
                    mem.sys_wr <= cpu_req.wr;
                end else if (win == `RBM_WIN2 && win2_ram) begin
                    mem.ram_addr <= {ctrl_r[`RBM_CTRL_RAMBANK_BIT], cpu_req.addr[13:0]};
                    mem.ram_rd <= cpu_req.rd;
                    mem.ram_wr <= cpu_req.wr && !ctrl_r[`RBM_CTRL_RAMWP_BIT];
                end else begin
                    // bank times 4000 or fixed low page
                    mem.rom_addr <= vec_area ? {5'h00, cpu_req.addr[13:0]}
                                             : {bank_phys, cpu_req.addr[13:0]};
                    mem.rom_rd <= cpu_req.rd;
                    mem.rom_wr <= cpu_req.wr && !ctrl_r[`RBM_CTRL_DEVWP_BIT];
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_write(logic [15:0] a);
        cpu_req.wr && cpu_req.addr == a;
    endsequence

    sequence s_read_win(logic [1:0] w);
        cpu_req.rd && cpu_req.addr[15:14] == w;
    endsequence

    AST_PAGE0_LOAD: assert property (
        s_write(`RBM_ADDR_PAGE0) |=> page0_r == $past(cpu_req.wdata))
        else $error("page 0 register did not load");

    AST_WIN1_BANK: assert property (
        s_read_win(`RBM_WIN1) |=> mem.rom_rd
            && mem.rom_addr[18:14] == 5'($past(page1_r) + {$past(ctrl_r[1:0]), 3'h0})
            && mem.rom_addr[13:0] == $past(cpu_req.addr[13:0]))
        else $error("window 1 read went to wrong ROM bank");

    AST_WIN2_ROM: assert property (
        s_read_win(`RBM_WIN2) ##0 !win2_ram |=> mem.rom_rd
            && mem.rom_addr[18:14] == $past(page2_r[4:0]) + {$past(shift), 3'h0})
        else $error("window 2 ROM read used wrong page");

    AST_WIN0_RANGE: assert property (
        cpu_req.rd && cpu_req.addr < 16'h4000 |=> mem.rom_rd && !mem.ram_rd && !mem.sys_rd)
        else $error("window 0 read did not reach ROM");

    AST_VECTOR_FIXED: assert property (
        cpu_req.rd && cpu_req.addr < 16'h0400 |=> mem.rom_addr == {9'h000, $past(cpu_req.addr[9:0])})
        else $error("vector area not fixed to ROM bottom");

    AST_ROTATE: assert property (
        cpu_req.rd && cpu_req.addr[15:14] == 2'h0 && cpu_req.addr >= 16'h0400
            |=> mem.rom_addr[18:14] == 5'((($past(page0_r) & 8'h1F) + 8'($past(shift)) * 8'h08))
        ) else $error("bank rotation wrong");

    AST_RAM_SELECT: assert property (
        s_read_win(`RBM_WIN2) ##0 win2_ram |=> mem.ram_rd && !mem.rom_rd
            && mem.ram_addr[14] == $past(ctrl_r[2]))
        else $error("window 2 RAM select wrong");

    AST_DEV_WP: assert property (
        cpu_req.wr && cpu_req.addr[15] == 1'b0 && ctrl_r[7] |=> !mem.rom_wr)
        else $error("ROM write passed board protect");

    AST_RAM_WP: assert property (
        cpu_req.wr && cpu_req.addr[15:14] == 2'h2 && win2_ram
            |=> mem.ram_wr == !$past(ctrl_r[4]))
        else $error("RAM write protect misapplied");

    AST_TOP_WRITE: assert property (
        s_write(`RBM_ADDR_RAM_CTRL) |=> mem.sys_wr ##0 ctrl_r == $past(cpu_req.wdata))
        else $error("control write not captured");

    AST_IDLE_QUIET: assert property (
        !cpu_req.rd && !cpu_req.wr |=> !(mem.rom_rd || mem.rom_wr || mem.ram_rd
            || mem.ram_wr || mem.sys_rd || mem.sys_wr))
        else $error("strobe without request");

    // ****************************************
    // Register checks
    // ****************************************
    sequence s_write_win(logic [1:0] w);
        cpu_req.wr && cpu_req.addr[15:14] == w;
    endsequence

    sequence s_read_reg(logic [15:0] a);
        cpu_req.rd && cpu_req.addr == a;
    endsequence

    AST_PAGE1_LOAD: assert property (
        s_write(`RBM_ADDR_PAGE1) |=> page1_r == $past(cpu_req.wdata))
        else $error("page 1 register did not load");

    AST_PAGE2_LOAD: assert property (
        s_write(`RBM_ADDR_PAGE2) |=> page2_r == $past(cpu_req.wdata))
        else $error("page 2 register did not load");

    AST_REGS_HOLD: assert property (
        !(cpu_req.wr && reg_hit) |=> $stable(ctrl_r) && $stable(page0_r)
            && $stable(page1_r) && $stable(page2_r))
        else $error("register changed without a write");

    AST_READ_CTRL: assert property (
        s_read_reg(`RBM_ADDR_RAM_CTRL) |=> reg_rd.valid && reg_rd.data == $past(ctrl_r))
        else $error("control register read back wrong");

    AST_READ_PAGE0: assert property (
        s_read_reg(`RBM_ADDR_PAGE0) |=> reg_rd.valid && reg_rd.data == $past(page0_r))
        else $error("page 0 read back wrong");

    AST_READ_PAGE1: assert property (
        s_read_reg(`RBM_ADDR_PAGE1) |=> reg_rd.valid && reg_rd.data == $past(page1_r))
        else $error("page 1 read back wrong");

    AST_READ_PAGE2: assert property (
        s_read_reg(`RBM_ADDR_PAGE2) |=> reg_rd.valid && reg_rd.data == $past(page2_r))
        else $error("page 2 read back wrong");

    AST_NO_ANSWER: assert property (
        !(cpu_req.rd && reg_hit) |=> !reg_rd.valid && reg_rd.data == 8'h00)
        else $error("register answer without a register read");

    // ****************************************
    // Window checks
    // ****************************************
    AST_WIN1_ONLY_ROM: assert property (
        s_read_win(`RBM_WIN1) |=> !mem.ram_rd && !mem.sys_rd)
        else $error("window 1 read left ROM");

    AST_BANK_OFFSET: assert property (
        cpu_req.rd && !cpu_req.addr[15] && cpu_req.addr >= 16'h0400
            |=> mem.rom_addr[13:0] == $past(cpu_req.addr[13:0]))
        else $error("offset inside bank wrong");

    AST_VECTOR_WRITE: assert property (
        cpu_req.wr && cpu_req.addr < 16'h0400 && !ctrl_r[7]
            |=> mem.rom_wr && mem.rom_addr == {9'h000, $past(cpu_req.addr[9:0])})
        else $error("vector area write not fixed to ROM bottom");

    AST_ONE_TARGET: assert property (
        cpu_req.rd |=> $onehot({mem.rom_rd, mem.ram_rd, mem.sys_rd}))
        else $error("read did not reach exactly one memory");

    AST_RAM_WRITE: assert property (
        s_write_win(`RBM_WIN2) ##0 win2_ram && !ctrl_r[4]
            |=> mem.ram_wr && !mem.rom_wr && mem.ram_addr[13:0] == $past(cpu_req.addr[13:0]))
        else $error("open RAM write not passed on");

    AST_WIN2_ROM_WP: assert property (
        s_write_win(`RBM_WIN2) ##0 !win2_ram && ctrl_r[7] |=> !mem.rom_wr && !mem.ram_wr)
        else $error("window 2 ROM write passed board protect");

    AST_WIN3_READ: assert property (
        s_read_win(`RBM_WIN3) |=> mem.sys_rd && !mem.rom_rd && !mem.ram_rd
            && mem.sys_addr == $past(cpu_req.addr[13:0]))
        else $error("window 3 read not sent to system RAM");

    AST_WIN3_WRITE: assert property (
        s_write_win(`RBM_WIN3) |=> mem.sys_wr && !mem.rom_wr && !mem.ram_wr
            && mem.wdata == $past(cpu_req.wdata))
        else $error("window 3 write not sent to system RAM");

    AST_ROM_WRITE_OPEN: assert property (
        cpu_req.wr && !cpu_req.addr[15] && !ctrl_r[7] |=> mem.rom_wr
            && mem.wdata == $past(cpu_req.wdata))
        else $error("ROM write blocked with protect clear");

endmodule
`default_nettype wire

//--- pkg/rbm_defines.svh
// Constants of the ROM bank mapper: register addresses, fields, windows, reset values
`ifndef RBM_DEFINES_SVH
`define RBM_DEFINES_SVH

// ****************************************
// Register addresses
// ****************************************
`define RBM_ADDR_RAM_CTRL 16'hFFFC
`define RBM_ADDR_PAGE0 16'hFFFD
`define RBM_ADDR_PAGE1 16'hFFFE
`define RBM_ADDR_PAGE2 16'hFFFF

// ****************************************
// Fields of the frame 2 RAM control register
// ****************************************
`define RBM_CTRL_SHIFT_LSB 0
`define RBM_CTRL_SHIFT_MSB 1
`define RBM_CTRL_RAMBANK_BIT 2
`define RBM_CTRL_RAMSEL_BIT 3
`define RBM_CTRL_RAMWP_BIT 4
`define RBM_CTRL_DEVWP_BIT 7

// ****************************************
// Windows and fixed vector area
// ****************************************
`define RBM_WIN0 2'h0
`define RBM_WIN1 2'h1
`define RBM_WIN2 2'h2
`define RBM_WIN3 2'h3
`define RBM_VEC_LIMIT 16'h0400
`define RBM_BANK_BITS 5

// ****************************************
// Reset values
// ****************************************
`define RBM_RST_CTRL 8'h00
`define RBM_RST_PAGE0 8'h00
`define RBM_RST_PAGE1 8'h01
`define RBM_RST_PAGE2 8'h02

`endif

//--- pkg/rbm_pkg.sv
// Types of the ROM bank mapper
`default_nettype none
package rbm_pkg;

    // One processor access, valid for the cycle in which rd or wr is high
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } rbm_cpu_req_t;

    // Strobes and addresses towards the memory chips
    typedef struct packed {
        logic [18:0] rom_addr;
        logic rom_rd;
        logic rom_wr;
        logic [14:0] ram_addr;
        logic ram_rd;
        logic ram_wr;
        logic [13:0] sys_addr;
        logic sys_rd;
        logic sys_wr;
        logic [7:0] wdata;
    } rbm_mem_t;

    // Register read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rbm_rd_t;

endpackage
`default_nettype wire

//--- verification/rbm_cpu_model.sv
// Processor bus model issuing single-cycle reads and writes
`timescale 1ns/1ps
`default_nettype none
module rbm_cpu_model (
    // Clock
    input wire logic clk_sys,
    // Processor requests
    output var rbm_pkg::rbm_cpu_req_t cpu_req
);
    initial cpu_req = '0;

    // One access, launched just after an edge and taken at the next edge
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
        cpu_req = '{addr: a, wdata: d, rd: ~w, wr: w};
        @(posedge clk_sys);
        #1;
    endtask

    // Idle bus shows inverted values, never the last request
    task automatic idle();
        cpu_req = '{addr: ~cpu_req.addr, wdata: ~cpu_req.wdata, rd: 1'b0, wr: 1'b0};
    endtask
endmodule
`default_nettype wire

//--- verification/tb_rbm_mapper.sv
// Self-checking bench for the ROM bank mapper
`timescale 1ns/1ps
`default_nettype none
`include "rbm_defines.svh"
module tb_rbm_mapper;
    logic clk_sys;
    logic rstn;
    rbm_pkg::rbm_cpu_req_t cpu_req;
    rbm_pkg::rbm_rd_t reg_rd;
    rbm_pkg::rbm_mem_t mem;
    logic [7:0] regs [4];
    logic [33:0] exp_q [$];
    logic req_d = 1'b0;
    logic [15:0] a;
    int miscompares = 0;
    int cmp_count = 0;
    int seed;
    int r;

    rbm_mapper rbm_mapper_i (.clk_sys(clk_sys), .rstn(rstn), .cpu_req(cpu_req),
        .reg_rd(reg_rd), .mem(mem));
    rbm_cpu_model rbm_cpu_model_i (.clk_sys(clk_sys), .cpu_req(cpu_req));

    // ****************************************
    // Expected outcome: {strobes, address, data}
    // ****************************************
    // decode model
    function automatic logic [33:0] predict(input logic [15:0] ad, input logic [7:0] d,
        input logic w);
        logic [6:0] s;
        logic [18:0] ma;
        logic [7:0] dt;
        logic [4:0] bank;
        dt = w ? d : 8'h00;
        bank = regs[ad[15:14] + 2'h1][4:0] + {regs[0][1:0], 3'h0};
        if (ad[15:14] == 2'h3) begin
            s = {5'h00, ~w, w};
            ma = {5'h00, ad[13:0]};
            if (!w && ad >= `RBM_ADDR_RAM_CTRL) begin
                s[6] = 1'b1;
                dt = regs[ad[1:0]];
            end
        end else if (ad[15:14] == 2'h2 && regs[0][3]) begin
            s = {3'h0, ~w, w & ~regs[0][4], 2'h0};
            ma = {4'h0, regs[0][2], ad[13:0]};
        end else begin
            s = {1'b0, ~w, w & ~regs[0][7], 4'h0};
            ma = (ad < `RBM_VEC_LIMIT) ? {5'h00, ad[13:0]} : {bank, ad[13:0]};
        end
        if (s == 7'h00) begin
            ma = '0;
            dt = 8'h00;
        end
        return {s, ma, dt};
    endfunction

    function automatic logic [33:0] observe();
        logic [6:0] s;
        s = {reg_rd.valid, mem.rom_rd, mem.rom_wr, mem.ram_rd, mem.ram_wr, mem.sys_rd,
            mem.sys_wr};
        return {s, (s[5] | s[4]) ? mem.rom_addr : (s[3] | s[2]) ? {4'h0, mem.ram_addr}
            : (s[1] | s[0]) ? {5'h00, mem.sys_addr} : 19'h00000,
            s[6] ? reg_rd.data : (s[4] | s[2] | s[0]) ? mem.wdata : 8'h00};
    endfunction

    // ****************************************
    // Drivers, checker and verdict
    // ****************************************
    task automatic op(input logic [15:0] ad, input logic [7:0] d, input logic w);
        exp_q.push_back(predict(ad, d, w));
        if (w && ad >= `RBM_ADDR_RAM_CTRL) regs[ad[1:0]] = d;
        rbm_cpu_model_i.access(ad, d, w);
    endtask

    task automatic do_reset();
        rstn = 1'b0;
        regs = '{8'h00, 8'h00, 8'h01, 8'h02};
        repeat (4) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
    endtask

    task automatic rd_regs();
        for (int k = 0; k < 4; k++) begin
            op({14'h3FFF, k[1:0]}, 8'h00, 1'b0);
        end
    endtask

    task automatic cmp_sig(input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) req_d <= cpu_req.rd | cpu_req.wr;

    always @(negedge clk_sys) begin
        if (req_d === 1'b1) begin
            cmp_sig(exp_q.pop_front(), observe());
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end

    initial begin
        seed = 89;
        do_reset();
        rd_regs();
        op(`RBM_ADDR_PAGE2, 8'h02, 1'b1);
        // Back-to-back traffic biased to registers, vectors and window 2
        for (int i = 0; i < 600; i++) begin
            r = $random(seed);
            case (r[1:0])
                2'h0: a = r[31:16];
                2'h1: a = {14'h3FFF, r[3:2]};
                2'h2: a = {6'h00, r[25:16]};
                default: a = {2'h2, r[29:16]};
            endcase
            op(a, r[11:4], r[12]);
        end
        rd_regs();
        // Reset in mid-run restores register values
        rbm_cpu_model_i.idle();
        repeat (2) @(posedge clk_sys);
        #1;
        do_reset();
        rd_regs();
        rbm_cpu_model_i.idle();
        repeat (3) @(posedge clk_sys);
        // Every request must have been answered
        if (exp_q.size() != 0) miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
